//--- logic/cec_regs.svh
`ifndef CEC_REGS_SVH
`define CEC_REGS_SVH

// register byte offsets, one aligned word each
`define CEC_CTRL0_OFF 8'h00
`define CEC_TARGET0_OFF 8'h04
`define CEC_STATUS0_OFF 8'h08
`define CEC_CTRL1_OFF 8'h10
`define CEC_TARGET1_OFF 8'h14
`define CEC_STATUS1_OFF 8'h18
`define CEC_LANE_MASK 8'hFC
`define CEC_IDX_BIT 4

// control word fields
`define CEC_EN_BIT 0
`define CEC_DIR_BIT 1
`define CEC_HOLD_BIT 2
`define CEC_CLRW_BIT 3
`define CEC_CASC_BIT 4

// status word fields
`define CEC_CNT_MSB 16
`define CEC_TC_BIT 17
`define CEC_WRAP_BIT 18

// reset values
`define CEC_EN_RST 1'h1
`define CEC_HOLD_RST 1'h0
`define CEC_CLRW_RST 1'h0
`define CEC_CASC_RST 1'h0
`define CEC_TARGET_RST 17'h0_0000
`define CEC_ADDR_RST 8'h00

// count range
`define CEC_CNT_ZERO 17'h0_0000
`define CEC_CNT_ONE 17'h0_0001
`define CEC_CNT_MAX 17'h1_869F

// bus answers
`define CEC_RESP_OKAY 2'h0
`define CEC_RESP_SLVERR 2'h2
`define CEC_WORD_ZERO 32'h0000_0000
`define CEC_STRB_ZERO 4'h0

`endif

//--- logic/cec_pkg.sv
package cec_pkg;

  // count and target value, range 0 to 99999
  typedef logic [16:0] cec_count_type;

  // counting direction
  typedef enum logic {
    CEC_DIR_UP = 1'b0,
    CEC_DIR_DOWN = 1'b1
  } cec_dir_type;

  // register selected by a bus address
  typedef enum logic [1:0] {
    CEC_SEL_CTRL = 2'h0,
    CEC_SEL_TARGET = 2'h1,
    CEC_SEL_STATUS = 2'h2,
    CEC_SEL_NONE = 2'h3
  } cec_sel_type;

endpackage

//--- logic/cec_sync.sv
`timescale 1ns/1ps
// brings one event pin into the clock domain and marks its rising edges
module cec_sync (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic pin_in,
  output logic rise_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;

  // three stage chain, first stage feeds only the second
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a change counts once the two later stages agree
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      level_r <= 1'b0;
      rise_out <= 1'b0;
    end else begin
      rise_out <= (s2_r == s3_r) && s3_r && !level_r;
      if (s2_r == s3_r) begin
        level_r <= s3_r;
      end
    end
  end
endmodule

//--- logic/cec_counter.sv
`timescale 1ns/1ps
`include "cec_regs.svh"
// one counting unit: steps on accepted edges, raises terminal count, wraps
module cec_counter (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic step_in,
  input wire logic hold_in,
  input wire logic clr_wrap_in,
  input wire cec_pkg::cec_dir_type dir_in,
  input wire cec_pkg::cec_count_type target_in,
  output cec_pkg::cec_count_type count_out,
  output logic tc_out,
  output logic wrap_out
);
  import cec_pkg::*;

  cec_count_type up_nxt;
  cec_count_type dn_nxt;

  assign up_nxt = count_out + `CEC_CNT_ONE;
  assign dn_nxt = count_out - `CEC_CNT_ONE;

  // count and terminal count move on accepted edges, and load the start value while held
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      count_out <= `CEC_CNT_ZERO;
      tc_out <= 1'b0;
    end else if (hold_in) begin
      count_out <= (dir_in == CEC_DIR_DOWN) ? target_in : `CEC_CNT_ZERO;
      tc_out <= 1'b0;
    end else if (step_in) begin
      if (tc_out) begin
        count_out <= (dir_in == CEC_DIR_DOWN) ? target_in : `CEC_CNT_ZERO;
        tc_out <= 1'b0;
      end else if (dir_in == CEC_DIR_UP) begin
        if (count_out >= target_in) begin
          // target moved below the count: stop at target
          count_out <= target_in;
          tc_out <= 1'b1;
        end else begin
          count_out <= up_nxt;
          tc_out <= (up_nxt == target_in);
        end
      end else begin
        if (count_out == `CEC_CNT_ZERO) begin
          tc_out <= 1'b1;
        end else begin
          count_out <= dn_nxt;
          tc_out <= (dn_nxt == `CEC_CNT_ZERO);
        end
      end
    end
  end

  // wrap flag latches on the step after terminal count; set beats clear
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wrap_out <= 1'b0;
    end else if (step_in && tc_out && !hold_in) begin
      wrap_out <= 1'b1;
    end else if (clr_wrap_in) begin
      wrap_out <= 1'b0;
    end
  end
endmodule

//--- logic/cec_top.sv
`timescale 1ns/1ps
`include "cec_regs.svh"
// What this block does
// - counters change only on edges of their event input, never on levels, except that the hold setting reloads the start value
// - two independent counters, each with own settings, outputs and flags
// - counting up, each accepted edge adds one until count equals target
// - counting up, terminal count rises when count becomes equal to target
// - counting up, next edge clears count, sets wrap, drops terminal count
// - counting down, each accepted edge subtracts one until count is zero
// - counting down, terminal count rises as soon as count becomes zero
// - counting down, next edge reloads target, sets wrap, drops terminal count
// - cascaded counter takes an edge only when upstream terminal count held
// - terminal count leads the wrap flag by exactly one event edge
// - enable setting defaults on, may change at run time; disabled never counts
// - target programmable 0 to 99999; count read-only, stays within range
module cec_top (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [1:0] event_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [7:0] s_axi_araddr_in,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic [1:0] terminal_count_out,
  output logic [1:0] wrap_flag_out
);
  import cec_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // functions

  // address to register kind
  function automatic cec_sel_type cec_decode(input logic [7:0] addr);
    logic [7:0] word_addr;
    cec_sel_type sel;
    word_addr = addr & `CEC_LANE_MASK;
    sel = CEC_SEL_NONE;
    if (word_addr == `CEC_CTRL0_OFF || word_addr == `CEC_CTRL1_OFF) begin
      sel = CEC_SEL_CTRL;
    end else if (word_addr == `CEC_TARGET0_OFF || word_addr == `CEC_TARGET1_OFF) begin
      sel = CEC_SEL_TARGET;
    end else if (word_addr == `CEC_STATUS0_OFF || word_addr == `CEC_STATUS1_OFF) begin
      sel = CEC_SEL_STATUS;
    end
    return sel;
  endfunction

  // one word of the chosen kind
  function automatic logic [31:0] cec_pick(input cec_sel_type sel,
      input logic [31:0] ctrl, input logic [31:0] tgt, input logic [31:0] stat);
    logic [31:0] word;
    word = `CEC_WORD_ZERO;
    unique case (sel)
      CEC_SEL_CTRL: word = ctrl;
      CEC_SEL_TARGET: word = tgt;
      CEC_SEL_STATUS: word = stat;
      CEC_SEL_NONE: word = `CEC_WORD_ZERO;
    endcase
    return word;
  endfunction

  // byte strobes merge new data over old
  function automatic logic [31:0] cec_merge(input logic [31:0] old_word,
      input logic [31:0] new_word, input logic [3:0] strb);
    logic [31:0] word;
    word = old_word;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        word[b*8 +: 8] = new_word[b*8 +: 8];
      end
    end
    return word;
  endfunction

  // targets above the count range are held at the top
  function automatic cec_count_type cec_clamp(input cec_count_type value);
    return (value > `CEC_CNT_MAX) ? `CEC_CNT_MAX : value;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // declarations

  logic aw_hold_r;
  logic [7:0] aw_addr_r;
  logic w_hold_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic wr_go;
  cec_sel_type wr_sel;
  logic wr_idx;
  logic [31:0] wr_word;
  cec_sel_type rd_sel;
  logic rd_idx;

  logic [1:0] en_r;
  cec_dir_type dir_r [2];
  logic [1:0] hold_r;
  logic [1:0] clrw_r;
  logic casc_r;
  cec_count_type target_r [2];

  logic [1:0] rise_w;
  logic [1:0] up_ok;
  logic [1:0] acc;
  logic [1:0] tc_w;
  logic [1:0] wrap_w;
  cec_count_type cnt_w [2];
  logic [31:0] ctrl_word [2];
  logic [31:0] target_word [2];
  logic [31:0] status_word [2];

  //////////////////////////////////////////////////////////////////////////
  // write channels: address and data taken in either order

  assign s_axi_awready_out = !aw_hold_r && !s_axi_bvalid_out;
  assign s_axi_wready_out = !w_hold_r && !s_axi_bvalid_out;
  assign wr_go = aw_hold_r && w_hold_r;
  assign wr_sel = cec_decode(aw_addr_r);
  assign wr_idx = aw_addr_r[`CEC_IDX_BIT];
  assign wr_word = cec_merge(cec_pick(wr_sel, ctrl_word[wr_idx], target_word[wr_idx],
      status_word[wr_idx]), w_data_r, w_strb_r);

  // write address holding stage
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= `CEC_ADDR_RST;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_hold_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr_in;
    end else if (wr_go) begin
      aw_hold_r <= 1'b0;
    end
  end

  // write data holding stage
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      w_hold_r <= 1'b0;
      w_data_r <= `CEC_WORD_ZERO;
      w_strb_r <= `CEC_STRB_ZERO;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_hold_r <= 1'b1;
      w_data_r <= s_axi_wdata_in;
      w_strb_r <= s_axi_wstrb_in;
    end else if (wr_go) begin
      w_hold_r <= 1'b0;
    end
  end

  // write response once both halves are in
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `CEC_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out <= (wr_sel == CEC_SEL_NONE) ? `CEC_RESP_SLVERR : `CEC_RESP_OKAY;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // settings registers

  // control fields of both counters
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      en_r <= {2{`CEC_EN_RST}};
      hold_r <= {2{`CEC_HOLD_RST}};
      clrw_r <= {2{`CEC_CLRW_RST}};
      casc_r <= `CEC_CASC_RST;
      dir_r[0] <= CEC_DIR_UP;
      dir_r[1] <= CEC_DIR_UP;
    end else if (wr_go && wr_sel == CEC_SEL_CTRL) begin
      en_r[wr_idx] <= wr_word[`CEC_EN_BIT];
      // direction is trusted to change only while configuring
      dir_r[wr_idx] <= cec_dir_type'(wr_word[`CEC_DIR_BIT]);
      hold_r[wr_idx] <= wr_word[`CEC_HOLD_BIT];
      clrw_r[wr_idx] <= wr_word[`CEC_CLRW_BIT];
      if (wr_idx) begin
        casc_r <= wr_word[`CEC_CASC_BIT];
      end
    end
  end

  // target values, held inside the count range
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      target_r[0] <= `CEC_TARGET_RST;
      target_r[1] <= `CEC_TARGET_RST;
    end else if (wr_go && wr_sel == CEC_SEL_TARGET) begin
      target_r[wr_idx] <= cec_clamp(wr_word[`CEC_CNT_MSB:0]);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read channel: data one cycle after the address is taken

  assign s_axi_arready_out = !s_axi_rvalid_out;
  assign rd_sel = cec_decode(s_axi_araddr_in);
  assign rd_idx = s_axi_araddr_in[`CEC_IDX_BIT];

  // read data and response
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= `CEC_WORD_ZERO;
      s_axi_rresp_out <= `CEC_RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= cec_pick(rd_sel, ctrl_word[rd_idx], target_word[rd_idx],
          status_word[rd_idx]);
      s_axi_rresp_out <= (rd_sel == CEC_SEL_NONE) ? `CEC_RESP_SLVERR : `CEC_RESP_OKAY;
    end else if (s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // counters

  // the second counter may be gated by the first one's terminal count
  assign up_ok[0] = 1'b1;
  assign up_ok[1] = !casc_r || tc_w[0];
  assign terminal_count_out = tc_w;
  assign wrap_flag_out = wrap_w;

  for (genvar i = 0; i < 2; i++) begin : g_unit
    // register images of this counter
    always_comb begin
      ctrl_word[i] = `CEC_WORD_ZERO;
      ctrl_word[i][`CEC_EN_BIT] = en_r[i];
      ctrl_word[i][`CEC_DIR_BIT] = dir_r[i];
      ctrl_word[i][`CEC_HOLD_BIT] = hold_r[i];
      ctrl_word[i][`CEC_CLRW_BIT] = clrw_r[i];
      ctrl_word[i][`CEC_CASC_BIT] = (i == 1) ? casc_r : 1'b0;
      target_word[i] = `CEC_WORD_ZERO;
      target_word[i][`CEC_CNT_MSB:0] = target_r[i];
      status_word[i] = `CEC_WORD_ZERO;
      status_word[i][`CEC_CNT_MSB:0] = cnt_w[i];
      status_word[i][`CEC_TC_BIT] = tc_w[i];
      status_word[i][`CEC_WRAP_BIT] = wrap_w[i];
    end

    // an edge counts only when enabled and not gated off
    assign acc[i] = rise_w[i] && en_r[i] && up_ok[i];

    cec_sync u_sync (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .pin_in(event_in[i]),
      .rise_out(rise_w[i])
    );

    cec_counter u_cnt (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .step_in(acc[i]),
      .hold_in(hold_r[i]),
      .clr_wrap_in(clrw_r[i]),
      .dir_in(dir_r[i]),
      .target_in(target_r[i]),
      .count_out(cnt_w[i]),
      .tc_out(tc_w[i]),
      .wrap_out(wrap_w[i])
    );
  end

  //////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb_main @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  for (genvar k = 0; k < 2; k++) begin : g_chk
    property p_idle_stable;
      !acc[k] && !hold_r[k] |=> cnt_w[k] == $past(cnt_w[k]) && tc_w[k] == $past(tc_w[k]);
    endproperty
    a_idle_stable: assert property (p_idle_stable)
      else $error("count moved without an accepted edge");

    property p_up_step;
      acc[k] && !hold_r[k] && !tc_w[k] && dir_r[k] == CEC_DIR_UP
        && cnt_w[k] < target_r[k] |=> cnt_w[k] == $past(cnt_w[k]) + `CEC_CNT_ONE;
    endproperty
    a_up_step: assert property (p_up_step)
      else $error("up count did not add one");

    property p_up_tc;
      acc[k] && !hold_r[k] && !tc_w[k] && dir_r[k] == CEC_DIR_UP
        && cnt_w[k] + `CEC_CNT_ONE == target_r[k] |=> tc_w[k] && cnt_w[k] == $past(target_r[k]);
    endproperty
    a_up_tc: assert property (p_up_tc)
      else $error("terminal count missing at target");

    property p_up_wrap;
      acc[k] && !hold_r[k] && tc_w[k] && dir_r[k] == CEC_DIR_UP
        |=> cnt_w[k] == `CEC_CNT_ZERO && wrap_w[k] && !tc_w[k];
    endproperty
    a_up_wrap: assert property (p_up_wrap)
      else $error("up wrap wrong");

    property p_dn_step;
      acc[k] && !hold_r[k] && !tc_w[k] && dir_r[k] == CEC_DIR_DOWN
        && cnt_w[k] != `CEC_CNT_ZERO |=> cnt_w[k] == $past(cnt_w[k]) - `CEC_CNT_ONE;
    endproperty
    a_dn_step: assert property (p_dn_step)
      else $error("down count did not subtract one");

    property p_dn_tc;
      acc[k] && !hold_r[k] && !tc_w[k] && dir_r[k] == CEC_DIR_DOWN
        && cnt_w[k] == `CEC_CNT_ONE |=> tc_w[k] && cnt_w[k] == `CEC_CNT_ZERO;
    endproperty
    a_dn_tc: assert property (p_dn_tc)
      else $error("terminal count missing at zero");

    property p_dn_wrap;
      acc[k] && !hold_r[k] && tc_w[k] && dir_r[k] == CEC_DIR_DOWN
        |=> cnt_w[k] == $past(target_r[k]) && wrap_w[k] && !tc_w[k];
    endproperty
    a_dn_wrap: assert property (p_dn_wrap)
      else $error("down reload wrong");

    property p_tc_leads;
      $rose(wrap_w[k]) |-> $past(tc_w[k]) && $past(acc[k]);
    endproperty
    a_tc_leads: assert property (p_tc_leads)
      else $error("wrap set without a prior terminal count");

    property p_disabled;
      !en_r[k] && !hold_r[k] |=> cnt_w[k] == $past(cnt_w[k]);
    endproperty
    a_disabled: assert property (p_disabled)
      else $error("disabled counter moved");

    property p_range;
      cnt_w[k] <= `CEC_CNT_MAX && target_r[k] <= `CEC_CNT_MAX;
    endproperty
    a_range: assert property (p_range)
      else $error("count or target out of range");

    // start value follows the direction and target of the cycle that loaded it
    property p_hold;
      hold_r[k] ##1 hold_r[k] |-> !tc_w[k] && cnt_w[k] ==
        (($past(dir_r[k]) == CEC_DIR_DOWN) ? $past(target_r[k]) : `CEC_CNT_ZERO);
    endproperty
    a_hold: assert property (p_hold)
      else $error("reset setting did not hold start value");

    property p_wrap_clear;
      wrap_w[k] && clrw_r[k] |=> !wrap_w[k] || $past(acc[k] && tc_w[k]);
    endproperty
    a_wrap_clear: assert property (p_wrap_clear)
      else $error("wrap flag not cleared");

    property p_wrap_sticky;
      wrap_w[k] && !clrw_r[k] |=> wrap_w[k];
    endproperty
    a_wrap_sticky: assert property (p_wrap_sticky)
      else $error("wrap flag dropped on its own");
  end

  property p_cascade_gate;
    casc_r && !tc_w[0] && !hold_r[1] |=> cnt_w[1] == $past(cnt_w[1]);
  endproperty
  a_cascade_gate: assert property (p_cascade_gate)
    else $error("cascaded counter moved while upstream idle");

  property p_bresp_hold;
    s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out);
  endproperty
  a_bresp_hold: assert property (p_bresp_hold)
    else $error("write response dropped early");

  cover property (acc[0] && tc_w[0] && dir_r[0] == CEC_DIR_UP);
  cover property (acc[0] && tc_w[0] && dir_r[0] == CEC_DIR_DOWN);
  cover property (casc_r && acc[1] && tc_w[0]);
  cover property (s_axi_rvalid_out && s_axi_rready_in && s_axi_rdata_out[`CEC_WRAP_BIT]);
endmodule

//--- verif/cec_event_src.sv
`timescale 1ns/1ps
// wired event source: one clean pulse per request, idle low between pulses
module cec_event_src (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic go_in,
  input wire logic [3:0] hi_in,
  output logic pin_out,
  output logic busy_out
);
  logic [3:0] cnt_r;

  ////////////////////////////////////////////////////////////////////////////////
  // high for at least 3 cycles, then low for 4, so every edge is caught once
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pin_out <= 1'h0;
      busy_out <= 1'h0;
      cnt_r <= 4'h0;
    end else if (!busy_out) begin
      if (go_in) begin
        pin_out <= 1'h1;
        busy_out <= 1'h1;
        cnt_r <= (hi_in < 4'h3) ? 4'h3 : hi_in;
      end
    end else if (cnt_r > 4'h1) begin
      cnt_r <= cnt_r - 4'h1;
    end else if (pin_out) begin
      pin_out <= 1'h0;
      cnt_r <= 4'h4;
    end else begin
      busy_out <= 1'h0;
    end
  end
endmodule

//--- verif/cec_top_test.sv
`timescale 1ns/1ps
`include "cec_regs.svh"
module cec_top_test;
  import cec_pkg::*;
  logic clk_in = 1'h0;
  logic sys_rst_in = 1'h1;
  logic awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0, bready = 1'h1, rready = 1'h1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hf;
  logic [3:0] hi = 4'h3;
  logic [1:0] go = 2'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, tc, wrap, ev, busy, be;
  logic [31:0] rdata;
  logic [33:0] re;
  logic [1:0] bexp_q[$];
  logic [33:0] rexp_q[$];
  cec_count_type t1;
  integer seed = 32'h400a;
  integer errors = 0;
  integer cmp_count = 0;
  integer cycles = 0;

  always #2 clk_in = ~clk_in;

  cec_top u_cec_top (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .event_in(ev),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_awaddr_in(awaddr),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .terminal_count_out(tc),
    .wrap_flag_out(wrap));
  cec_event_src u_cec_event_src0 (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .go_in(go[0]),
    .hi_in(hi), .pin_out(ev[0]), .busy_out(busy[0]));
  cec_event_src u_cec_event_src1 (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .go_in(go[1]),
    .hi_in(hi), .pin_out(ev[1]), .busy_out(busy[1]));

  ////////////////////////////////////////////////////////////////////////////////
  // verdict and comparisons
  task automatic tally_and_finish();
    if (errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t read data %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t response %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t flag pin %b expected %b", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // bus master tasks; each notes its expected answer before it starts
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad;
    logic wd;
    ad = 1'h0;
    wd = 1'h0;
    bexp_q.push_back(er);
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    awaddr <= a;
    wdata <= d;
    while (!(ad && wd)) begin
      @(posedge clk_in);
      if (awvalid && awready) begin
        ad = 1'h1;
        awvalid <= 1'h0;
      end
      if (wvalid && wready) begin
        wd = 1'h1;
        wvalid <= 1'h0;
      end
    end
    do @(posedge clk_in); while (!bvalid);
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    rexp_q.push_back({er, d});
    arvalid <= 1'h1;
    araddr <= a;
    do @(posedge clk_in); while (!arready);
    arvalid <= 1'h0;
    do @(posedge clk_in); while (!rvalid);
  endtask

  // status word and flag pins of one counter
  task automatic chk(input int i, input logic [16:0] c, input logic t, input logic w);
    axi_rd(`CEC_STATUS0_OFF + 8'(i * 16), {13'h0, w, t, c}, `CEC_RESP_OKAY);
    cmp_bit(tc[i], t);
    cmp_bit(wrap[i], w);
  endtask

  // one event pulse of random width, then let the count settle
  task automatic pulse(input int i);
    go[i] <= 1'h1;
    hi <= 4'($random(seed));
    @(posedge clk_in);
    go[i] <= 1'h0;
    do @(posedge clk_in); while (busy[i]);
    repeat (2) @(posedge clk_in);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // monitor: oldest note against each answer as it appears
  always @(posedge clk_in) begin
    if (bvalid && bready) begin
      be = bexp_q.pop_front();
      cmp_resp(bresp, be);
    end
    if (rvalid && rready) begin
      re = rexp_q.pop_front();
      cmp_resp(rresp, re[33:32]);
      cmp_word(rdata, re[31:0]);
    end
  end

  // hang guard
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'h0;
    @(posedge clk_in);
    for (int i = 0; i < 2; i++) begin
      axi_rd(8'(i * 16), 32'h0000_0001, `CEC_RESP_OKAY);
      axi_rd(8'(i * 16 + 4), 32'h0000_0000, `CEC_RESP_OKAY);
      chk(i, 17'h0_0000, 1'h0, 1'h0);
    end
    axi_rd(8'h20, 32'h0000_0000, `CEC_RESP_SLVERR);
    axi_wr(8'h20, 32'h0000_0005, `CEC_RESP_SLVERR);
    axi_wr(`CEC_STATUS0_OFF, 32'hffff_ffff, `CEC_RESP_OKAY);
    chk(0, 17'h0_0000, 1'h0, 1'h0);
    axi_wr(`CEC_TARGET0_OFF, 32'h0000_0002, `CEC_RESP_OKAY);
    pulse(0);
    chk(0, 17'h0_0001, 1'h0, 1'h0);
    pulse(0);
    chk(0, 17'h0_0002, 1'h1, 1'h0);
    pulse(0);
    chk(0, 17'h0_0000, 1'h0, 1'h1);
    pulse(0);
    chk(0, 17'h0_0001, 1'h0, 1'h1);
    axi_wr(`CEC_CTRL0_OFF, 32'h0000_0009, `CEC_RESP_OKAY);
    axi_wr(`CEC_CTRL0_OFF, 32'h0000_0001, `CEC_RESP_OKAY);
    chk(0, 17'h0_0001, 1'h0, 1'h0);
    axi_wr(`CEC_CTRL0_OFF, 32'h0000_0000, `CEC_RESP_OKAY);
    pulse(0);
    chk(0, 17'h0_0001, 1'h0, 1'h0);
    axi_wr(`CEC_CTRL0_OFF, 32'h0000_0005, `CEC_RESP_OKAY);
    chk(0, 17'h0_0000, 1'h0, 1'h0);
    // direction changed only while held
    axi_wr(`CEC_CTRL0_OFF, 32'h0000_0007, `CEC_RESP_OKAY);
    chk(0, 17'h0_0002, 1'h0, 1'h0);
    axi_wr(`CEC_CTRL0_OFF, 32'h0000_0003, `CEC_RESP_OKAY);
    pulse(0);
    chk(0, 17'h0_0001, 1'h0, 1'h0);
    pulse(0);
    chk(0, 17'h0_0000, 1'h1, 1'h0);
    pulse(0);
    chk(0, 17'h0_0002, 1'h0, 1'h1);
    // target range: clamp and a random legal value
    axi_wr(`CEC_TARGET1_OFF, 32'h0001_ffff, `CEC_RESP_OKAY);
    axi_rd(`CEC_TARGET1_OFF, 32'h0001_869f, `CEC_RESP_OKAY);
    t1 = 17'($unsigned($random(seed)) % 100000);
    axi_wr(`CEC_TARGET1_OFF, {15'h0, t1}, `CEC_RESP_OKAY);
    axi_rd(`CEC_TARGET1_OFF, {15'h0, t1}, `CEC_RESP_OKAY);
    axi_wr(`CEC_TARGET1_OFF, 32'h0000_0001, `CEC_RESP_OKAY);
    // cascade: counter 1 gated by terminal count of counter 0
    axi_wr(`CEC_CTRL0_OFF, 32'h0000_0005, `CEC_RESP_OKAY);
    axi_wr(`CEC_CTRL0_OFF, 32'h0000_0001, `CEC_RESP_OKAY);
    axi_wr(`CEC_CTRL1_OFF, 32'h0000_0011, `CEC_RESP_OKAY);
    pulse(1);
    chk(1, 17'h0_0000, 1'h0, 1'h0);
    pulse(0);
    pulse(0);
    chk(0, 17'h0_0002, 1'h1, 1'h1);
    pulse(1);
    chk(1, 17'h0_0001, 1'h1, 1'h0);
    pulse(1);
    chk(1, 17'h0_0000, 1'h0, 1'h1);
    chk(0, 17'h0_0002, 1'h1, 1'h1);
    @(posedge clk_in);
    tally_and_finish();
  end
endmodule
